// ===== csd_defs.vh
// Constants for the compare-skip and decimal-adjust execution unit.
// Assumes inclusion by bare name from the unit's source file.
`ifndef CSD_DEFS_VH
`define CSD_DEFS_VH

// Register byte offsets on the APB slave
`define CSD_OFS_CTRL      8'h00
`define CSD_OFS_WORK      8'h04
`define CSD_OFS_FLAGS     8'h08
`define CSD_OFS_BANK      8'h0c
`define CSD_OFS_INDEX     8'h10
`define CSD_OFS_STATE     8'h14

// Field positions
`define CSD_CTRL_EXT      0
`define CSD_FLAG_C        0
`define CSD_FLAG_DC       1
`define CSD_ST_BUSY       0
`define CSD_ST_SKIP       1
`define CSD_ST_TWO        2
`define CSD_ST_CNT_LO     8

// Reset values
`define CSD_RST_CTRL      1'h0
`define CSD_RST_WORK      8'h00
`define CSD_RST_BANK      4'h0
`define CSD_RST_INDEX     12'h000

// Opcode patterns (upper byte, bank bit masked off; decimal adjust is a whole word)
`define CSD_OP_LT         7'h30
`define CSD_OP_EQ         7'h31
`define CSD_OP_GT         7'h32
`define CSD_OP_DAW        16'h0007

// Two-word opcode prefixes
`define CSD_TW_MOVE4      4'hc
`define CSD_TW_CALL7      7'h76
`define CSD_TW_GOTO8      8'hef
`define CSD_TW_LOAD10     10'h3b8

// Access bank split and extended-mode limit
`define CSD_ACC_LIMIT     8'h60
`define CSD_IDX_MAX       8'h5f
`define CSD_ACC_HIGH      4'hf

// Phases per instruction cycle, last phase index
`define CSD_LAST_PHASE    2'h3

`endif

// ===== csd_exec_unit.v
// Execution unit for compare-and-skip and decimal-adjust instructions.
// Assumes fetch, data memory and APB master share pclk; memory answers
// in the same cycle as its read strobe.
//
// Operation
// - Decode skip-if-greater from 0110 010a pattern
// - Decode skip-if-less from 0110 000a pattern
// - File greater than W: flush next, idle
// - File less than W: flush next, idle
// - Unsigned subtract compare, operands and flags untouched
// - One word; one cycle, two when skipping
// - Skip over two-word instruction takes three cycles
// - a=0 access bank, a=1 bank select register
// - a=0, extended, f<=95: indexed literal offset
// - Low nibble plus 6 if above 9/DC
// - High nibble plus 6 plus carry if needed
// - Decimal adjust works in place on W
// - File equal to W: flush next, idle
`include "csd_defs.vh"
`timescale 1ns/10ps

module csd_exec_unit
(
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Instruction issue from fetch pipeline
  input  wire        instr_valid,
  input  wire [15:0] instr_word,
  input  wire [15:0] next_word,
  output reg         instr_ready,
  // Data memory read port
  output reg  [11:0] mem_addr,
  output reg         mem_rd,
  input  wire [7:0]  mem_rdata,
  // Pipeline status
  output reg         flush_next,
  output reg         idle_cycle,
  output reg         exec_done
);

  // Operation kinds
  localparam [2:0] K_NONE = 3'd0;
  localparam [2:0] K_EQ   = 3'd1;
  localparam [2:0] K_GT   = 3'd2;
  localparam [2:0] K_LT   = 3'd3;
  localparam [2:0] K_DAW  = 3'd4;

  // Sequencer states
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_EXEC = 2'd1;
  localparam [1:0] ST_NOP  = 2'd2;

  // Instruction kind from opcode
  function [2:0] decode_kind;
    input [15:0] w;
    begin
      if (w[15:9] == `CSD_OP_GT)
        decode_kind = K_GT;
      else if (w[15:9] == `CSD_OP_LT)
        decode_kind = K_LT;
      else if (w[15:9] == `CSD_OP_EQ)
        decode_kind = K_EQ;
      else if (w == `CSD_OP_DAW)
        decode_kind = K_DAW;
      else
        decode_kind = K_NONE;
    end
  endfunction

  // True when the opcode has a second program word
  function is_two_word;
    input [15:0] w;
    begin
      is_two_word = (w[15:12] == `CSD_TW_MOVE4) ||
                    (w[15:9] == `CSD_TW_CALL7) ||
                    (w[15:8] == `CSD_TW_GOTO8) ||
                    (w[15:6] == `CSD_TW_LOAD10);
    end
  endfunction

  // Data memory address of the file operand
  function [11:0] file_address;
    input        a;
    input [7:0]  f;
    input [3:0]  bank;
    input        ext;
    input [11:0] index;
    begin
      if (a)
        file_address = {bank, f};
      else if (ext && (f <= `CSD_IDX_MAX))
        file_address = index + {4'h0, f};
      else if (f < `CSD_ACC_LIMIT)
        file_address = {4'h0, f};
      else
        file_address = {`CSD_ACC_HIGH, f};
    end
  endfunction

  // Packed BCD correction: {carry, result}
  function [8:0] bcd_adjust;
    input [7:0] w;
    input       c;
    input       dc;
    reg   [4:0] lo;
    reg   [4:0] hi;
    begin
      lo = {1'b0, w[3:0]};
      if ((w[3:0] > 4'h9) || dc)
        lo = lo + 5'h06;
      hi = {1'b0, w[7:4]} + {4'h0, lo[4]};
      if ((hi > 5'h09) || c)
        hi = hi + 5'h06;
      bcd_adjust = {c | (hi > 5'h0f), hi[3:0], lo[3:0]};
    end
  endfunction

  // Software-visible state
  reg        ext_enable;
  reg [7:0]  work;
  reg        flag_c;
  reg        flag_dc;
  reg [3:0]  bank;
  reg [11:0] index_base;
  reg [7:0]  skip_count;
  reg        last_skip;

  // Sequencer state
  reg [1:0]  state;
  reg [1:0]  phase;
  reg [2:0]  kind;
  reg        bank_bit;
  reg [7:0]  file_ofs;
  reg        next_two;
  reg [7:0]  file_byte;
  reg        take_skip;
  reg        nops_left;

  // Combinational helpers
  reg [8:0]  diff;
  reg        cmp_true;
  reg [8:0]  adjusted;
  reg [31:0] next_prdata;
  reg        next_pslverr;
  wire       apb_access;
  wire       apb_write;
  wire       daw_write;

  // Completing transfer and its write side
  assign apb_access = psel & penable & pready;
  assign apb_write  = apb_access & pwrite;
  assign daw_write  = (state == ST_EXEC) && (phase == `CSD_LAST_PHASE) && (kind == K_DAW);

  // Compare by unsigned subtraction, nothing written back
  always @*
  begin
    diff = {1'b0, file_byte} - {1'b0, work};
    case (kind)
      K_EQ:    cmp_true = (diff[7:0] == 8'h00);
      K_GT:    cmp_true = ~diff[8] && (diff[7:0] != 8'h00);
      K_LT:    cmp_true = diff[8];
      default: cmp_true = 1'b0;
    endcase
    adjusted = bcd_adjust(work, flag_c, flag_dc);
  end

  // Register read mux and unmapped decode
  always @*
  begin
    next_prdata  = 32'h00000000;
    next_pslverr = 1'b0;
    case (paddr)
      `CSD_OFS_CTRL:  next_prdata[`CSD_CTRL_EXT] = ext_enable;
      `CSD_OFS_WORK:  next_prdata[7:0] = work;
      `CSD_OFS_FLAGS:
      begin
        next_prdata[`CSD_FLAG_C]  = flag_c;
        next_prdata[`CSD_FLAG_DC] = flag_dc;
      end
      `CSD_OFS_BANK:  next_prdata[3:0] = bank;
      `CSD_OFS_INDEX: next_prdata[11:0] = index_base;
      `CSD_OFS_STATE:
      begin
        next_prdata[`CSD_ST_BUSY] = (state != ST_IDLE);
        next_prdata[`CSD_ST_SKIP] = last_skip;
        next_prdata[`CSD_ST_TWO]  = next_two;
        next_prdata[`CSD_ST_CNT_LO+7:`CSD_ST_CNT_LO] = skip_count;
      end
      default: next_pslverr = 1'b1;
    endcase
  end

  // APB handshake: one wait state, data and error with pready
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & penable & ~pready;
      prdata  <= (psel & penable & ~pready & ~pwrite) ? next_prdata : 32'h00000000;
      pslverr <= psel & penable & ~pready & next_pslverr;
    end
  end

  // Configuration registers written over APB
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ext_enable <= `CSD_RST_CTRL;
      bank       <= `CSD_RST_BANK;
      index_base <= `CSD_RST_INDEX;
    end
    else if (apb_write)
    begin
      if (paddr == `CSD_OFS_CTRL)
        ext_enable <= pwdata[`CSD_CTRL_EXT];
      if (paddr == `CSD_OFS_BANK)
        bank <= pwdata[3:0];
      if (paddr == `CSD_OFS_INDEX)
        index_base <= pwdata[11:0];
    end
  end

  // Working register and flags; instruction write beats software
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      work    <= `CSD_RST_WORK;
      flag_c  <= 1'b0;
      flag_dc <= 1'b0;
    end
    else if (daw_write)
    begin
      work   <= adjusted[7:0];
      flag_c <= adjusted[8];
    end
    else if (apb_write)
    begin
      if (paddr == `CSD_OFS_WORK)
        work <= pwdata[7:0];
      if (paddr == `CSD_OFS_FLAGS)
      begin
        flag_c  <= pwdata[`CSD_FLAG_C];
        flag_dc <= pwdata[`CSD_FLAG_DC];
      end
    end
  end

  // Instruction sequencer over four phases per cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state       <= ST_IDLE;
      phase       <= 2'h0;
      kind        <= K_NONE;
      bank_bit    <= 1'b0;
      file_ofs    <= 8'h00;
      next_two    <= 1'b0;
      file_byte   <= 8'h00;
      take_skip   <= 1'b0;
      nops_left   <= 1'b0;
      last_skip   <= 1'b0;
      skip_count  <= 8'h00;
      instr_ready <= 1'b0;
      mem_addr    <= 12'h000;
      mem_rd      <= 1'b0;
      flush_next  <= 1'b0;
      idle_cycle  <= 1'b0;
      exec_done   <= 1'b0;
    end
    else
    begin
      exec_done <= 1'b0;
      mem_rd    <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          instr_ready <= 1'b1;
          idle_cycle  <= 1'b0;
          flush_next  <= 1'b0;
          if (instr_valid && instr_ready)
          begin
            // Q1: decode; capture the prefetched word's length
            kind        <= decode_kind(instr_word);
            bank_bit    <= instr_word[8];
            file_ofs    <= instr_word[7:0];
            next_two    <= is_two_word(next_word);
            take_skip   <= 1'b0;
            instr_ready <= 1'b0;
            state       <= ST_EXEC;
            phase       <= 2'h1;
            if (decode_kind(instr_word) != K_DAW && decode_kind(instr_word) != K_NONE)
            begin
              // Q2 read strobe for the file operand
              mem_addr <= file_address(instr_word[8], instr_word[7:0], bank,
                                       ext_enable, index_base);
              mem_rd   <= 1'b1;
            end
          end
        end
        ST_EXEC:
        begin
          phase <= phase + 2'h1;
          if (phase == 2'h1)
            file_byte <= mem_rdata;
          if (phase == 2'h2)
            take_skip <= cmp_true;
          if (phase == `CSD_LAST_PHASE)
          begin
            if (take_skip)
            begin
              // Skip: one idle cycle, two over a two-word instruction
              state      <= ST_NOP;
              nops_left  <= next_two;
              flush_next <= 1'b1;
              idle_cycle <= 1'b1;
              last_skip  <= 1'b1;
              skip_count <= skip_count + 8'h01;
            end
            else
            begin
              // No skip: single cycle done
              state       <= ST_IDLE;
              exec_done   <= 1'b1;
              instr_ready <= 1'b1;
              if (kind != K_NONE && kind != K_DAW)
                last_skip <= 1'b0;
            end
          end
        end
        ST_NOP:
        begin
          phase <= phase + 2'h1;
          if (phase == `CSD_LAST_PHASE)
          begin
            if (nops_left)
              nops_left <= 1'b0;
            else
            begin
              state       <= ST_IDLE;
              flush_next  <= 1'b0;
              idle_cycle  <= 1'b0;
              exec_done   <= 1'b1;
              instr_ready <= 1'b1;
            end
          end
        end
        default:
        begin
          state <= ST_IDLE;
          phase <= 2'h0;
        end
      endcase
    end
  end

endmodule

// ===== csd_mem_model.sv
// Data memory model for the compare-skip unit.
// Assumes reads answered in the same cycle as mem_rd, one clock.
`timescale 1ns/10ps
module csd_mem_model
(
  // Clock
  input  wire        pclk,
  // Read port
  input  wire [11:0] mem_addr,
  input  wire        mem_rd,
  output wire [7:0]  mem_rdata
);
  reg  [7:0] last = 8'h00;

  // Keep last byte so idle data never repeats it
  always @(posedge pclk)
    if (mem_rd)
      last <= mem_addr[7:0] ^ mem_addr[11:4];

  // Contents are the address folded on itself
  assign mem_rdata = mem_rd ? mem_addr[7:0] ^ mem_addr[11:4] : ~last;
endmodule

// ===== csd_exec_unit_properties.sv
// Checker for the compare-skip and decimal-adjust unit.
// Assumes a bind to csd_exec_unit, all in the pclk domain.
`timescale 1ns/10ps
module csd_exec_unit_properties
(
  // Clock and reset
  input wire        pclk,
  input wire        presetn,
  // APB
  input wire        psel,
  input wire        penable,
  input wire        pready,
  input wire        pslverr,
  // Issue and memory
  input wire        instr_valid,
  input wire        instr_ready,
  input wire [15:0] instr_word,
  input wire [11:0] mem_addr,
  input wire        mem_rd,
  // Status
  input wire        flush_next,
  input wire        idle_cycle,
  input wire        exec_done
);
  // Take edge and compare opcodes
  wire take = instr_valid && instr_ready;
  wire cmp  = instr_word[15:11] == 5'h0c && instr_word[10:9] != 2'h3;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
  a_ready_time: assert property ($rose(penable) && psel |=> pready) else $error("pready late");
  a_err_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
  a_read_once: assert property (take && cmp |=> mem_rd ##1 !mem_rd)
    else $error("compare read wrong");
  a_daw_noread: assert property (take && instr_word == 16'h0007 |=> !mem_rd [*4])
    else $error("adjust reads memory");
  a_access_high: assert property (take && cmp && !instr_word[8] && instr_word[7:0] >= 8'h60
    |=> mem_addr == {4'hf, $past(instr_word[7:0])}) else $error("access bank wrong");
  a_done_four: assert property (take |=> !exec_done [*3] ##1 (exec_done || flush_next))
    else $error("done timing");
  a_flush_span: assert property ($rose(flush_next) |-> flush_next [*4] ##1
    ((!flush_next && exec_done) or (flush_next [*4] ##1 (!flush_next && exec_done))))
    else $error("skip span wrong");
  a_idle_match: assert property (flush_next == idle_cycle) else $error("idle differs");
  a_busy_take: assert property (take |=> !instr_ready) else $error("ready after take");
endmodule

bind csd_exec_unit csd_exec_unit_properties i_csd_exec_unit_properties (
  .pclk        (pclk),
  .presetn     (presetn),
  .psel        (psel),
  .penable     (penable),
  .pready      (pready),
  .pslverr     (pslverr),
  .instr_valid (instr_valid),
  .instr_ready (instr_ready),
  .instr_word  (instr_word),
  .mem_addr    (mem_addr),
  .mem_rd      (mem_rd),
  .flush_next  (flush_next),
  .idle_cycle  (idle_cycle),
  .exec_done   (exec_done)
);

// ===== compare_skip_decimal_adjust_test.sv
// Testbench for the compare-skip and decimal-adjust unit.
// Assumes csd_exec_unit and the memory model share pclk.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin compares = compares + 1; if ((got) !== (ex)) \
  begin fails = fails + 1; $display("ERROR %s exp %h got %h", nm, ex, got); end end
module compare_skip_decimal_adjust_test;
  reg          pclk = 0;
  reg          presetn = 0;
  reg          psel = 0;
  reg          penable = 0;
  reg          pwrite = 0;
  reg  [7:0]   paddr = 8'h00;
  reg  [31:0]  pwdata = 32'h0;
  reg          instr_valid = 0;
  reg  [15:0]  instr_word = 16'h0;
  reg  [15:0]  next_word = 16'h0;
  wire [31:0]  prdata;
  wire         pready, pslverr, instr_ready, mem_rd, flush_next, idle_cycle, exec_done;
  wire [11:0]  mem_addr;
  wire [7:0]   mem_rdata;
  wire [127:0] tws = 128'hc123_ec00_ef55_ee00_0000_6400_1234_f000;
  reg  [31:0]  seed = 32'h546e;
  reg  [31:0]  r, q;
  reg  [15:0]  iw, nw;
  reg  [11:0]  idx;
  reg  [8:0]   d;
  reg  [7:0]   wv, f;
  reg  [3:0]   bank;
  reg  [1:0]   fl;
  reg          e, ext, sk;
  reg  [11:0]  ma;
  reg  [7:0]   sc = 8'h00;
  reg          ls = 1'b0;
  integer      n, cy, ec, nr;
  integer      fails = 0;
  integer      compares = 0;

  csd_exec_unit i_csd_exec_unit (
    .pclk        (pclk),
    .presetn     (presetn),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .paddr       (paddr),
    .pwdata      (pwdata),
    .prdata      (prdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .instr_valid (instr_valid),
    .instr_word  (instr_word),
    .next_word   (next_word),
    .instr_ready (instr_ready),
    .mem_addr    (mem_addr),
    .mem_rd      (mem_rd),
    .mem_rdata   (mem_rdata),
    .flush_next  (flush_next),
    .idle_cycle  (idle_cycle),
    .exec_done   (exec_done)
  );
  csd_mem_model i_csd_mem_model (
    .pclk      (pclk),
    .mem_addr  (mem_addr),
    .mem_rd    (mem_rd),
    .mem_rdata (mem_rdata)
  );

  // Clock
  always #20 pclk = ~pclk;

  function [31:0] xs();
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      xs = seed;
    end
  endfunction
  function [7:0] fb(input [11:0] a);
    fb = a[7:0] ^ a[11:4];
  endfunction
  // Expected file address from bank bit, bank and mode
  function [11:0] fa(input [15:0] i);
    fa = i[8] ? {bank, i[7:0]} : (ext && i[7:0] <= 8'h5f) ? idx + i[7:0]
      : {(i[7:0] >= 8'h60) ? 4'hf : 4'h0, i[7:0]};
  endfunction
  function tw(input [15:0] x);
    tw = x[15:12] == 4'hc || x[15:9] == 7'h76 || x[15:8] == 8'hef || x[15:6] == 10'h3b8;
  endfunction
  // Expected {carry, result} of decimal adjust
  function [8:0] decimal_adjust_op(input [7:0] w, input c, input dc);
    reg [4:0] lo, hi;
    begin
      lo = (w[3:0] > 9 || dc) ? w[3:0] + 5'h6 : {1'b0, w[3:0]};
      hi = (w[7:4] + lo[4] > 9 || c) ? w[7:4] + 5'h6 + lo[4] : w[7:4] + lo[4];
      decimal_adjust_op = {c | hi[4], hi[3:0], lo[3:0]};
    end
  endfunction

  // One APB transfer, held until pready
  task apb(input w, input [7:0] a, input [31:0] dt);
    reg rd;
    begin
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= dt;
      @(posedge pclk);
      penable <= 1;
      rd = 0;
      while (!rd)
      begin
        @(posedge pclk);
        rd = pready === 1;
        q = prdata;
        e = pslverr;
      end
      psel <= 0;
      penable <= 0;
    end
  endtask

  // Issue one instruction, count cycles to exec_done
  task issue(input [15:0] i, input [15:0] x);
    reg rd;
    begin
      @(posedge pclk);
      instr_valid <= 1;
      instr_word <= i;
      next_word <= x;
      rd = 0;
      while (!rd)
      begin
        @(posedge pclk);
        rd = instr_ready === 1;
      end
      instr_valid <= 0;
      cy = 0;
      nr = 0;
      rd = 0;
      while (!rd && cy < 20)
      begin
        @(negedge pclk);
        cy = cy + 1;
        rd = exec_done === 1;
        if (mem_rd === 1)
        begin
          nr = nr + 1;
          ma = mem_addr;
        end
      end
    end
  endtask

  task end_of_test;
    begin
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  // Main sequence
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    repeat (2) @(posedge pclk);
    for (n = 0; n < 5; n = n + 1)
      if (n != 2)
      begin
        apb(0, 8'(n * 4), 0);
        `CHK("reset value", 32'h0, q)
      end
    apb(0, 8'h18, 0);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 32'h0, q)
    for (n = 0; n < 60; n = n + 1)
    begin
      r = xs();
      ext = r[0];
      bank = r[7:4];
      idx = r[27:16];
      fl = r[13:12];
      r = xs();
      iw = {7'h30 + {5'h0, r[10:9]}, r[8], r[23:16]};
      nw = tws[16 * r[2:0] +: 16];
      f = fb(fa(iw));
      wv = (n % 3 == 0) ? f : r[31:24];
      apb(1, 8'h00, {31'h0, ext});
      apb(1, 8'h0c, {28'h0, bank});
      apb(1, 8'h10, {20'h0, idx});
      apb(1, 8'h04, {24'h0, wv});
      apb(1, 8'h08, {30'h0, fl});
      issue(iw, nw);
      case (iw[15:9])
        7'h30: sk = f < wv;
        7'h31: sk = f == wv;
        7'h32: sk = f > wv;
        default: sk = 0;
      endcase
      ec = sk ? (tw(nw) ? 12 : 8) : 4;
      `CHK("cycles", ec, cy)
      `CHK("reads", (iw[15:9] == 7'h33) ? 0 : 1, nr)
      if (iw[15:9] != 7'h33)
      begin
        ls = sk;
        `CHK("file address", fa(iw), ma)
      end
      if (sk)
        sc = sc + 8'h01;
      apb(0, 8'h14, 0);
      `CHK("state", {16'h0, sc, 5'h0, tw(nw), ls, 1'b0}, q)
      apb(0, 8'h04, 0);
      `CHK("work kept", {24'h0, wv}, q)
      apb(0, 8'h08, 0);
      `CHK("flags kept", {30'h0, fl}, q)
    end
    for (n = 0; n < 20; n = n + 1)
    begin
      r = xs();
      wv = (n == 0) ? 8'ha5 : (n == 1) ? 8'hce : r[7:0];
      fl = (n < 2) ? 2'h0 : r[9:8];
      d = decimal_adjust_op(wv, fl[0], fl[1]);
      apb(1, 8'h04, {24'h0, wv});
      apb(1, 8'h08, {30'h0, fl});
      issue(16'h0007, 16'h0);
      `CHK("adjust cycles", 4, cy)
      `CHK("adjust reads", 0, nr)
      apb(0, 8'h04, 0);
      `CHK("adjust work", {24'h0, d[7:0]}, q)
      apb(0, 8'h08, 0);
      `CHK("adjust flags", {30'h0, fl[1], d[8]}, q)
    end
    end_of_test;
  end

  // Watchdog
  initial
  begin
    #2000000;
    fails = fails + 1;
    end_of_test;
  end
endmodule
